// ### key_unlock_pkg.sv
package key_unlock_pkg;
   localparam logic [63:0] KEY_ERASE   = 64'h4E56_4D45_7261_7365;
   localparam logic [63:0] KEY_PROGRAM = 64'h4E56_4D50_726F_6720;
   localparam logic [63:0] KEY_USER_CONFIG_ROW = 64'h4E56_4D55_7326_7465;
   localparam int          KEY_BYTES   = 8;
   // Word offsets of registers (byte address = 4 * index)
   localparam logic [3:0]  IDX_KEY_STATE = 4'h7;
   localparam logic [3:0]  IDX_RESET_REQ = 4'h8;
   localparam logic [3:0]  IDX_SYS_CTRL  = 4'hA;
   localparam logic [3:0]  IDX_SYS_STATE = 4'hB;
   localparam logic [7:0]  RESET_SIG     = 8'h59;
   localparam logic [7:0]  RESET_CLEAR   = 8'h00;
   // Key state bits
   localparam int          KB_ERASE   = 3;
   localparam int          KB_PROGRAM = 4;
   localparam int          KB_USER_CONFIG_ROW = 5;
   // System control bits
   localparam int          CB_KEEPCLK = 0;
   localparam int          CB_FINAL   = 1;
   // System state bits
   localparam int          SB_LOCKED  = 0;
   localparam int          SB_ROWPROG = 2;
   localparam int          SB_NVM_PROGRAM_ACTIVE = 3;
   localparam int          SB_SLEEP   = 4;
   localparam int          SB_RSTSYS  = 5;
   localparam logic [7:0]  SYS_CTRL_RST = 8'h01;
   localparam int          ROW_BYTES  = 32;
   localparam logic [1:0]  BOD_ACTIVE_ON = 2'h1;
endpackage : key_unlock_pkg

// ### key_shift_if.sv
`timescale 1ns/1ps
interface key_shift_if;
   logic       byteValid;
   logic [7:0] byteData;
   logic       eraseHit;
   logic       programHit;
   logic       userRowHit;
   modport shifter (input byteValid, input byteData,
                    output eraseHit, output programHit, output userRowHit);
   modport owner   (output byteValid, output byteData,
                    input eraseHit, input programHit, input userRowHit);
endinterface : key_shift_if

// ### key_shifter.sv
`timescale 1ns/1ps
module key_shifter
   import key_unlock_pkg::*;
(
   // System
   input wire logic mclk,
   input wire logic srst,
   input wire logic clearKey,
   // Key bytes
   key_shift_if.shifter ks
);
   import key_unlock_pkg::*;

   logic [63:0] shift_r;
   logic [63:0] shift_nxt;
   logic [3:0]  count_r;
   logic [3:0]  count_nxt;
   logic        full;

   always_comb
   begin
      shift_nxt = shift_r;
      count_nxt = count_r;
      if (clearKey)
      begin
         count_nxt = '0;
      end
      else if (ks.byteValid)
      begin
         // LSB first: new byte enters at the top and walks down
         shift_nxt = {ks.byteData, shift_r[63:8]};
         count_nxt = (count_r == 4'(KEY_BYTES)) ? 4'h1 : 4'(count_r + 4'h1);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         shift_r <= '0;
         count_r <= '0;
      end
      else
      begin
         shift_r <= shift_nxt;
         count_r <= count_nxt;
      end
   end

   // Hits are one-cycle strobes after the eighth byte
   logic done_r;
   always_ff @(posedge mclk)
   begin
      if (srst)
         done_r <= 1'b0;
      else
         done_r <= ks.byteValid && !clearKey && (count_nxt == 4'(KEY_BYTES));
   end
   assign full          = done_r;
   assign ks.eraseHit   = full && (shift_r == KEY_ERASE);
   assign ks.programHit = full && (shift_r == KEY_PROGRAM);
   assign ks.userRowHit = full && (shift_r == KEY_USER_CONFIG_ROW);
endmodule : key_shifter

// ### sync_edge_event.sv
`timescale 1ns/1ps
module sync_edge_event
(
   // System
   input  wire logic mclk,
   input  wire logic srst,
   // Link
   input  wire logic linePin,
   input  wire logic inSync,
   output logic      edgeEvent
);
   logic [2:0] sync_r;
   logic       state_r;
   logic       state_nxt;
   logic       event_nxt;

   always_comb
   begin
      state_nxt = state_r;
      event_nxt = 1'b0;
      if (sync_r[1] == sync_r[2])
         state_nxt = sync_r[2];
      // Rising edge within sync character; no enable exists
      if (inSync && state_nxt && !state_r)
         event_nxt = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         sync_r    <= 3'h7;
         state_r   <= 1'b1;
         edgeEvent <= 1'b0;
      end
      else
      begin
         sync_r    <= {sync_r[1:0], linePin};
         state_r   <= state_nxt;
         edgeEvent <= event_nxt;
      end
   end
endmodule : sync_edge_event

// ### debug_key_unlock_sequencer.sv
`timescale 1ns/1ps
module debug_key_unlock_sequencer
   import key_unlock_pkg::*;
#(
   parameter int ROW_LIMIT = ROW_BYTES
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Key byte stream from the link layer
   input  wire logic        keyByteValid,
   input  wire logic [7:0]  keyByte,
   input  wire logic        linkReset,
   // Sync character pin
   input  wire logic        linePin,
   input  wire logic        inSyncChar,
   output logic             syncEdgeEvent,
   // System side status
   input  wire logic        lockbitsSet,
   input  wire logic        eraseDone,
   input  wire logic        programDone,
   input  wire logic        rowCopyDone,
   input  wire logic        sysSleepIdleOrDeeper,
   input  wire logic        cpuClockStopped,
   // System side controls
   output logic             systemReset,
   output logic             chipEraseStart,
   output logic             nvmProgEnable,
   output logic             rowProgEnable,
   output logic             rowCopyStart,
   output logic [1:0]       bodActiveForce,
   output logic             bodUseFuseLevel,
   output logic             keepClockOn,
   output logic             debugPhyClockOn,
   // Debug system bus access gate
   input  wire logic        dbgBusReq,
   input  wire logic        dbgBusWe,
   input  wire logic [15:0] dbgBusAdr,
   output logic             dbgBusGrant,
   output logic             dbgBusRefused
);
   import key_unlock_pkg::*;

   typedef enum logic [1:0]
   {
      ER_IDLE = 2'b00,
      ER_ARM  = 2'b01,
      ER_RUN  = 2'b11
   } erase_e;

   key_shift_if ks ();
   assign ks.byteValid = keyByteValid;
   assign ks.byteData  = keyByte;

   key_shifter u_shift
   (
      .mclk     (mclk),
      .srst     (srst),
      .clearKey (linkReset),
      .ks       (ks)
   );

   sync_edge_event u_sync
   (
      .mclk      (mclk),
      .srst      (srst),
      .linePin   (linePin),
      .inSync    (inSyncChar),
      .edgeEvent (syncEdgeEvent)
   );

   logic       eraseKey_r,   eraseKey_nxt;
   logic       progKey_r,    progKey_nxt;
   logic       rowKey_r,     rowKey_nxt;
   logic [7:0] resetReq_r,   resetReq_nxt;
   logic [7:0] sysCtrl_r,    sysCtrl_nxt;
   logic       progAct_r,    progAct_nxt;
   logic       rowAct_r,     rowAct_nxt;
   logic       final_r,      final_nxt;
   erase_e     erase_r,      erase_nxt;
   logic       ack_r,        ack_nxt;
   logic       err_r,        err_nxt;
   logic [31:0] rdat_r,      rdat_nxt;
   logic       rstHold;
   logic       wrStrobe;
   logic       rdStrobe;
   logic [3:0] idx;
   logic [7:0] keyState;
   logic [7:0] sysState;
   logic       mapped;

   assign idx      = wb_adr_i[5:2];
   assign wrStrobe = wb_cyc_i && wb_stb_i && !ack_r && !err_r && wb_we_i && wb_sel_i[0];
   assign rdStrobe = wb_cyc_i && wb_stb_i && !ack_r && !err_r && !wb_we_i;
   assign mapped   = (idx == IDX_KEY_STATE) || (idx == IDX_RESET_REQ)
                  || (idx == IDX_SYS_CTRL)  || (idx == IDX_SYS_STATE);
   assign rstHold  = (resetReq_r == RESET_SIG);

   always_comb
   begin
      keyState = 8'h00;
      keyState[KB_ERASE]   = eraseKey_r;
      keyState[KB_PROGRAM] = progKey_r;
      keyState[KB_USER_CONFIG_ROW] = rowKey_r;
      sysState = 8'h00;
      sysState[SB_LOCKED]  = lockbitsSet;
      sysState[SB_ROWPROG] = rowAct_r;
      sysState[SB_NVM_PROGRAM_ACTIVE] = progAct_r;
      sysState[SB_SLEEP]   = sysSleepIdleOrDeeper;
      sysState[SB_RSTSYS]  = rstHold;
   end

   // Key and mode state
   always_comb
   begin
      eraseKey_nxt = eraseKey_r;
      progKey_nxt  = progKey_r;
      rowKey_nxt   = rowKey_r;
      progAct_nxt  = progAct_r;
      rowAct_nxt   = rowAct_r;
      final_nxt    = final_r;
      erase_nxt    = erase_r;
      // Key hits set; only the exact signatures get here
      if (ks.eraseHit)
         eraseKey_nxt = 1'b1;
      if (ks.programHit)
         progKey_nxt = 1'b1;
      if (ks.userRowHit)
         rowKey_nxt = 1'b1;
      // Erase key leaves the program key alone
      case (erase_r)
         ER_IDLE:
            if (eraseKey_r && rstHold)
               erase_nxt = ER_ARM;
         ER_ARM:
            if (!rstHold)
               erase_nxt = ER_RUN;
         ER_RUN:
            if (eraseDone)
            begin
               erase_nxt    = ER_IDLE;
               eraseKey_nxt = ks.eraseHit;
            end
         default:
            erase_nxt = ER_IDLE;
      endcase
      // Programming mode enters while the reset request is held, with lock clear
      if (progKey_r && !lockbitsSet && rstHold)
         progAct_nxt = 1'b1;
      if (progAct_r && programDone && rstHold)
      begin
         progAct_nxt = 1'b0;
         progKey_nxt = ks.programHit;
      end
      // User row mode enters while the reset request is held, with lock set
      if (rowKey_r && lockbitsSet && rstHold && !final_r)
         rowAct_nxt = 1'b1;
      if (wrStrobe && idx == IDX_SYS_CTRL && wb_dat_i[CB_FINAL] && rowAct_r)
         final_nxt = 1'b1;
      if (final_r && rowCopyDone)
      begin
         rowAct_nxt = 1'b0;
         final_nxt  = 1'b0;
      end
      // Writing the key bit clears the user row key
      if (wrStrobe && idx == IDX_KEY_STATE && wb_dat_i[KB_USER_CONFIG_ROW] && !ks.userRowHit)
      begin
         rowKey_nxt = 1'b0;
         rowAct_nxt = 1'b0;
      end
      if (linkReset)
      begin
         progKey_nxt  = 1'b0;
         rowKey_nxt   = 1'b0;
         eraseKey_nxt = 1'b0;
         progAct_nxt  = 1'b0;
         rowAct_nxt   = 1'b0;
         final_nxt    = 1'b0;
         erase_nxt    = ER_IDLE;
      end
   end

   // Register writes
   always_comb
   begin
      resetReq_nxt = resetReq_r;
      sysCtrl_nxt  = sysCtrl_r;
      if (wrStrobe && mapped && idx == IDX_RESET_REQ)
         resetReq_nxt = wb_dat_i[7:0];
      if (wrStrobe && mapped && idx == IDX_SYS_CTRL)
         sysCtrl_nxt[CB_KEEPCLK] = wb_dat_i[CB_KEEPCLK];
      if (linkReset)
         resetReq_nxt = RESET_CLEAR;
   end

   // Bus answer: one cycle after the strobe, unmapped gives err
   always_comb
   begin
      ack_nxt  = 1'b0;
      err_nxt  = 1'b0;
      rdat_nxt = rdat_r;
      if (wb_cyc_i && wb_stb_i && !ack_r && !err_r)
      begin
         ack_nxt = mapped;
         err_nxt = !mapped;
      end
      if (rdStrobe)
      begin
         case (idx)
            IDX_KEY_STATE: rdat_nxt = {24'h000000, keyState};
            IDX_RESET_REQ: rdat_nxt = {24'h000000, resetReq_r};
            IDX_SYS_CTRL:  rdat_nxt = {24'h000000, sysCtrl_r};
            IDX_SYS_STATE: rdat_nxt = {24'h000000, sysState};
            default:       rdat_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         eraseKey_r <= 1'b0;
         progKey_r  <= 1'b0;
         rowKey_r   <= 1'b0;
         progAct_r  <= 1'b0;
         rowAct_r   <= 1'b0;
         final_r    <= 1'b0;
         erase_r    <= ER_IDLE;
         resetReq_r <= RESET_CLEAR;
         sysCtrl_r  <= SYS_CTRL_RST;
         ack_r      <= 1'b0;
         err_r      <= 1'b0;
         rdat_r     <= 32'h00000000;
      end
      else
      begin
         eraseKey_r <= eraseKey_nxt;
         progKey_r  <= progKey_nxt;
         rowKey_r   <= rowKey_nxt;
         progAct_r  <= progAct_nxt;
         rowAct_r   <= rowAct_nxt;
         final_r    <= final_nxt;
         erase_r    <= erase_nxt;
         resetReq_r <= resetReq_nxt;
         sysCtrl_r  <= sysCtrl_nxt;
         ack_r      <= ack_nxt;
         err_r      <= err_nxt;
         rdat_r     <= rdat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign wb_dat_o = rdat_r;

   assign systemReset     = rstHold;
   assign chipEraseStart  = (erase_r == ER_RUN);
   assign bodActiveForce  = (erase_r == ER_RUN) ? BOD_ACTIVE_ON : 2'h0;
   assign bodUseFuseLevel = (erase_r == ER_RUN);
   assign nvmProgEnable   = progAct_r && !lockbitsSet;
   assign rowProgEnable   = rowAct_r && lockbitsSet;
   assign rowCopyStart    = final_r;
   assign keepClockOn     = sysCtrl_r[CB_KEEPCLK];
   // Physical layer clock never gated by sleep
   assign debugPhyClockOn = 1'b1;

   // System bus gate
   logic busOk;
   always_comb
   begin
      busOk = 1'b1;
      if (lockbitsSet && !rowAct_r)
         busOk = 1'b0;
      if (cpuClockStopped && !sysCtrl_r[CB_KEEPCLK])
         busOk = 1'b0;
      if (rowAct_r && lockbitsSet)
      begin
         if (!dbgBusWe)
            busOk = 1'b0;
         else if (dbgBusAdr >= 16'(ROW_LIMIT))
            busOk = 1'b0;
      end
   end
   assign dbgBusGrant   = dbgBusReq && busOk;
   assign dbgBusRefused = dbgBusReq && !busOk;

   a_locked_bus_refused: assert property (@(posedge mclk) disable iff (srst)
      (dbgBusReq && lockbitsSet && !rowAct_r) |-> !dbgBusGrant)
      else $error("bus granted while locked");
   a_erase_keeps_prog: assert property (@(posedge mclk) disable iff (srst)
      (progKey_r && !linkReset && !(progAct_r && programDone && rstHold)) |=> progKey_r)
      else $error("program key lost");
   a_reset_follows_sig: assert property (@(posedge mclk) disable iff (srst)
      (wrStrobe && idx == IDX_RESET_REQ && wb_dat_i[7:0] == RESET_SIG && !linkReset)
      |=> systemReset)
      else $error("reset not asserted");
   a_link_reset_clears: assert property (@(posedge mclk) disable iff (srst)
      linkReset |=> !progKey_r && !rowKey_r)
      else $error("keys survive link reset");
   a_row_read_blocked: assert property (@(posedge mclk) disable iff (srst)
      (rowAct_r && lockbitsSet && dbgBusReq && !dbgBusWe) |-> dbgBusRefused)
      else $error("row mode read granted");
   a_row_range: assert property (@(posedge mclk) disable iff (srst)
      (rowAct_r && lockbitsSet && dbgBusReq && dbgBusAdr >= 16'(ROW_LIMIT)) |-> !dbgBusGrant)
      else $error("row write out of range");
   a_bod_during_erase: assert property (@(posedge mclk) disable iff (srst)
      chipEraseStart |-> bodActiveForce == BOD_ACTIVE_ON && bodUseFuseLevel)
      else $error("brownout not forced");
   a_sleep_flag: assert property (@(posedge mclk) disable iff (srst)
      (rdStrobe && idx == IDX_SYS_STATE) |=> wb_dat_o[SB_SLEEP] == $past(sysSleepIdleOrDeeper))
      else $error("sleep flag wrong");
   a_keepclk_default: assert property (@(posedge mclk)
      $fell(srst) |-> keepClockOn)
      else $error("keep clock not default one");
   a_bus_ack_one: assert property (@(posedge mclk) disable iff (srst)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o) |=> (wb_ack_o || wb_err_o))
      else $error("bus answer late");
   a_sync_event: assert property (@(posedge mclk) disable iff (srst)
      syncEdgeEvent |=> !syncEdgeEvent)
      else $error("event longer than one cycle");
   a_key_status: assert property (@(posedge mclk) disable iff (srst)
      (ks.programHit && !linkReset) |=> keyState[KB_PROGRAM])
      else $error("program key not activated");
   a_prog_entry: assert property (@(posedge mclk) disable iff (srst)
      $rose(progAct_r) |-> $past(progKey_r) && !$past(lockbitsSet) && $past(rstHold))
      else $error("programming entered without key");
   a_row_entry: assert property (@(posedge mclk) disable iff (srst)
      $rose(rowAct_r) |-> $past(rowKey_r) && $past(lockbitsSet) && $past(rstHold))
      else $error("row mode entered without key");
   a_final_in_row: assert property (@(posedge mclk) disable iff (srst)
      $rose(final_r) |-> $past(rowAct_r))
      else $error("final write outside row mode");
   a_erase_needs_key: assert property (@(posedge mclk) disable iff (srst)
      (erase_r == ER_IDLE && !eraseKey_r) |=> erase_r != ER_ARM)
      else $error("erase armed without key");
endmodule : debug_key_unlock_sequencer

// ### debugger_link_model.sv
`timescale 1ns/1ps
module debugger_link_model
   import key_unlock_pkg::*;
(
   // Clock
   input  wire logic mclk,
   // Key bytes
   output logic       keyByteValid,
   output logic [7:0] keyByte,
   // Single-wire line, idles high through its pull-up
   output logic       linePin,
   output logic       inSyncChar
);
   initial
   begin
      keyByteValid = 1'b0;
      keyByte      = 8'h00;
      linePin      = 1'b1;
      inSyncChar   = 1'b0;
   end

   // Data lines scramble between bytes so a stale byte never looks fresh
   task automatic sendKey(input logic [63:0] key);
      for (int i = 0; i < KEY_BYTES; i++)
      begin
         @(posedge mclk);
         keyByteValid <= 1'b1;
         keyByte      <= key[8*i +: 8];
         @(posedge mclk);
         keyByteValid <= 1'b0;
         keyByte      <= ~key[8*i +: 8];
         repeat ($urandom % 3) @(posedge mclk);
      end
   endtask : sendKey

   // Start bit, 0x55 LSB first, stop bit: five rising edges on the line
   task automatic sendSync(input int bitTime);
      logic [9:0] frame;
      frame = {1'b1, 8'h55, 1'b0};
      @(posedge mclk);
      inSyncChar <= 1'b1;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 10; i++)
      begin
         linePin <= frame[i];
         repeat (bitTime) @(posedge mclk);
      end
      repeat (8) @(posedge mclk);
      inSyncChar <= 1'b0;
   endtask : sendSync

   // A line glitch outside any sync character
   task automatic stray();
      @(posedge mclk);
      linePin <= 1'b0;
      repeat (6) @(posedge mclk);
      linePin <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask : stray
endmodule : debugger_link_model

// ### debug_key_unlock_sequencer_tb.sv
`timescale 1ns/1ps
module debug_key_unlock_sequencer_tb;
   import key_unlock_pkg::*;
   localparam int ROW_LIM = 32;
   logic        mclk, srst, wbCyc, wbStb, wbWe, wbAck, wbErr, e, linkReset;
   logic [5:0]  wbAdr;
   logic [31:0] wbDatW, wbDatR, q;
   logic [3:0]  wbSel;
   logic        keyByteValid, linePin, inSyncChar;
   logic [7:0]  keyByte;
   logic        lockbitsSet, eraseDone, programDone, rowCopyDone, sleepDeep, cpuStopped;
   logic        systemReset, chipEraseStart, nvmProgEnable, rowProgEnable, rowCopyStart;
   logic [1:0]  bodActiveForce;
   logic        bodUseFuseLevel, keepClockOn, phyClockOn, syncEdgeEvent;
   logic        busReq, busWe, busGrant, busRefused;
   logic [15:0] busAdr;
   logic [63:0] k;
   int          failures, total_checks, cycles, eventCount;
   int          rowAdr [4] = '{31, 32, 0, 63};

   debug_key_unlock_sequencer #(.ROW_LIMIT(ROW_LIM)) DUT (
      .mclk(mclk), .srst(srst),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
      .wb_err_o(wbErr), .keyByteValid(keyByteValid), .keyByte(keyByte),
      .linkReset(linkReset), .linePin(linePin), .inSyncChar(inSyncChar),
      .syncEdgeEvent(syncEdgeEvent), .lockbitsSet(lockbitsSet), .eraseDone(eraseDone),
      .programDone(programDone), .rowCopyDone(rowCopyDone),
      .sysSleepIdleOrDeeper(sleepDeep), .cpuClockStopped(cpuStopped),
      .systemReset(systemReset), .chipEraseStart(chipEraseStart),
      .nvmProgEnable(nvmProgEnable), .rowProgEnable(rowProgEnable),
      .rowCopyStart(rowCopyStart), .bodActiveForce(bodActiveForce),
      .bodUseFuseLevel(bodUseFuseLevel), .keepClockOn(keepClockOn),
      .debugPhyClockOn(phyClockOn), .dbgBusReq(busReq), .dbgBusWe(busWe),
      .dbgBusAdr(busAdr), .dbgBusGrant(busGrant), .dbgBusRefused(busRefused));

   debugger_link_model PARTNER (.mclk(mclk), .keyByteValid(keyByteValid),
      .keyByte(keyByte), .linePin(linePin), .inSyncChar(inSyncChar));

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Hang guard sized well above the several hundred cycles the tests need
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (syncEdgeEvent === 1'b1)
         eventCount <= eventCount + 1;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] keyWord(input logic er, input logic pr, input logic ur);
      keyWord = 32'h0000_0000;
      keyWord[KB_ERASE] = er;
      keyWord[KB_PROGRAM] = pr;
      keyWord[KB_USER_CONFIG_ROW] = ur;
   endfunction : keyWord

   function automatic logic [31:0] stateWord(input logic lk, input logic rst);
      stateWord = 32'h0000_0000;
      stateWord[SB_LOCKED] = lk;
      stateWord[SB_RSTSYS] = rst;
   endfunction : stateWord

   // Request held until ack or err is sampled, released at that same edge
   task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] d);
      int n;
      @(posedge mclk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= {idx, 2'b00};
      wbDatW <= {24'($urandom), d};
      wbSel  <= 4'h1 | 4'($urandom);
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 16);
      q = wbDatR;
      e = wbErr;
      check(n < 16, 1'b1, "bus answer");
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wb

   task automatic poll(input int pos, input logic val);
      int n;
      n = 0;
      do
      begin
         wb(1'b0, IDX_SYS_STATE, 8'h00);
         n++;
      end while (q[pos] !== val && n < 40);
      check(q[pos], val, "status poll");
   endtask : poll

   task automatic keyIs(input logic er, input logic pr, input logic ur);
      repeat (3) @(posedge mclk);
      wb(1'b0, IDX_KEY_STATE, 8'h00);
      check(q, keyWord(er, pr, ur), "key state");
   endtask : keyIs

   initial
   begin
      {wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel, linkReset} = '0;
      {eraseDone, programDone, rowCopyDone, sleepDeep, cpuStopped, busWe, busAdr} = '0;
      {failures, total_checks, cycles, eventCount} = '0;
      lockbitsSet = 1'b1;
      busReq = 1'b1;
      srst = 1'b1;
      void'($urandom(32'h2adc8e2f));
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      check(keepClockOn, 1'b1, "keep clock at reset");
      check(busRefused, 1'b1, "locked bus");
      wb(1'b0, IDX_SYS_CTRL, 8'h00);
      check(q, {24'h0, SYS_CTRL_RST}, "control reset");
      wb(1'b0, IDX_SYS_STATE, 8'h00);
      check(q, stateWord(1'b1, 1'b0), "state reset");
      wb(1'b1, 4'hE, 8'hFF);
      check(e, 1'b1, "unmapped index");
      for (int i = 0; i < 4; i++)
      begin
         k = {$urandom, $urandom};
         if (i == 0)
            k = KEY_ERASE ^ (64'h1 << ($urandom % 64));
         if (i == 1)
            k = KEY_USER_CONFIG_ROW ^ 64'h0100_0000_0000_0000;
         PARTNER.sendKey(k);
         keyIs(1'b0, 1'b0, 1'b0);
      end
      PARTNER.sendKey(KEY_PROGRAM);
      keyIs(1'b0, 1'b1, 1'b0);
      PARTNER.sendKey(KEY_ERASE);
      keyIs(1'b1, 1'b1, 1'b0);
      wb(1'b1, IDX_RESET_REQ, RESET_SIG);
      @(negedge mclk);
      check(systemReset, 1'b1, "reset asserted");
      wb(1'b0, IDX_SYS_STATE, 8'h00);
      check(q, stateWord(1'b1, 1'b1), "no program while locked");
      wb(1'b1, IDX_RESET_REQ, RESET_CLEAR);
      repeat (2) @(negedge mclk);
      check(systemReset, 1'b0, "reset released");
      check(chipEraseStart, 1'b1, "erase running");
      check({bodUseFuseLevel, bodActiveForce}, {1'b1, BOD_ACTIVE_ON}, "brownout forced");
      @(posedge mclk);
      lockbitsSet <= 1'b0;
      eraseDone <= 1'b1;
      repeat (3) @(posedge mclk);
      eraseDone <= 1'b0;
      poll(SB_LOCKED, 1'b0);
      check(chipEraseStart, 1'b0, "erase ended");
      check(busGrant, 1'b1, "unlocked bus");
      keyIs(1'b0, 1'b1, 1'b0);
      wb(1'b1, IDX_RESET_REQ, RESET_SIG);
      wb(1'b1, IDX_RESET_REQ, RESET_CLEAR);
      poll(SB_NVM_PROGRAM_ACTIVE, 1'b1);
      check(nvmProgEnable, 1'b1, "programming open");
      lockbitsSet <= 1'b1;
      @(negedge mclk);
      check(nvmProgEnable, 1'b0, "programming gated by lock");
      @(posedge mclk);
      lockbitsSet <= 1'b0;
      wb(1'b1, IDX_RESET_REQ, RESET_SIG);
      programDone <= 1'b1;
      repeat (2) @(posedge mclk);
      programDone <= 1'b0;
      poll(SB_NVM_PROGRAM_ACTIVE, 1'b0);
      keyIs(1'b0, 1'b0, 1'b0);
      wb(1'b1, IDX_RESET_REQ, RESET_CLEAR);
      PARTNER.sendKey(KEY_PROGRAM);
      linkReset <= 1'b1;
      repeat (2) @(posedge mclk);
      linkReset <= 1'b0;
      keyIs(1'b0, 1'b0, 1'b0);
      lockbitsSet <= 1'b1;
      PARTNER.sendKey(KEY_USER_CONFIG_ROW);
      keyIs(1'b0, 1'b0, 1'b1);
      wb(1'b1, IDX_RESET_REQ, RESET_SIG);
      wb(1'b1, IDX_RESET_REQ, RESET_CLEAR);
      poll(SB_ROWPROG, 1'b1);
      check(rowProgEnable, 1'b1, "row mode open");
      rowAdr[2] = $urandom % 32;
      for (int i = 0; i < 4; i++)
      begin
         busWe <= 1'b1;
         busAdr <= 16'(rowAdr[i]);
         @(negedge mclk);
         check(busGrant, rowAdr[i] < ROW_LIM, "row write window");
         @(posedge mclk);
      end
      busWe <= 1'b0;
      busAdr <= 16'h0000;
      @(negedge mclk);
      check(busRefused, 1'b1, "row readback");
      wb(1'b1, IDX_SYS_CTRL, 8'h03);
      @(negedge mclk);
      check(rowCopyStart, 1'b1, "row copy");
      @(posedge mclk);
      rowCopyDone <= 1'b1;
      repeat (2) @(posedge mclk);
      rowCopyDone <= 1'b0;
      poll(SB_ROWPROG, 1'b0);
      wb(1'b1, IDX_KEY_STATE, 8'h20);
      keyIs(1'b0, 1'b0, 1'b0);
      wb(1'b1, IDX_RESET_REQ, RESET_SIG);
      wb(1'b1, IDX_RESET_REQ, RESET_CLEAR);
      lockbitsSet <= 1'b0;
      sleepDeep <= 1'b1;
      cpuStopped <= 1'b1;
      poll(SB_SLEEP, 1'b1);
      check(busGrant, 1'b1, "emulated sleep");
      wb(1'b1, IDX_SYS_CTRL, 8'h00);
      @(negedge mclk);
      check({keepClockOn, busRefused}, 2'b01, "stopped clock");
      check(phyClockOn, 1'b1, "link clock in sleep");
      wb(1'b1, IDX_SYS_CTRL, SYS_CTRL_RST);
      eventCount = 0;
      PARTNER.sendSync(6 + $urandom % 8);
      PARTNER.stray();
      check(eventCount, 5, "sync edge events");
      results();
   end
endmodule : debug_key_unlock_sequencer_tb
